// ---- rtl/rqcm_consts.svh ----
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: byte addressing on the register port
// Notes: included by package users and the design modules
`ifndef RQCM_CONSTS_SVH
`define RQCM_CONSTS_SVH
`define RQCM_ADDR_W 20
`define RQCM_OFS_COUNT_LIMIT 20'h13094
`define RQCM_OFS_TIME 20'h13098
`define RQCM_OFS_CTRL 20'h13090
`define RQCM_OFS_IRQ_STATUS 20'h130a4
`define RQCM_OFS_IRQ_MASK 20'h130a8
`define RQCM_OFS_DECAY 20'h130ac
`define RQCM_CNT_LSB 0
`define RQCM_LIMIT_LSB 16
`define RQCM_PRESCALE_LSB 0
`define RQCM_FILL_THR_LSB 16
`define RQCM_EVT_MAX 16'hffff
`define RQCM_TIME_MAX 32'h0000ffff
`define RQCM_RESET_WORD 32'h00000000
`define RQCM_DECAY_DEFAULT 32'h00010000
`endif

// ---- rtl/rqcm_pkg.sv ----
// Purpose: shared types of the congestion monitor
// Assumes: nothing
// Notes: constants live in rqcm_consts.svh
package rqcm_pkg;
  // register selected by the port address
  typedef enum logic [2:0] {
    RQCM_SEL_NONE,
    RQCM_SEL_COUNT,
    RQCM_SEL_TIME,
    RQCM_SEL_CTRL,
    RQCM_SEL_STAT,
    RQCM_SEL_MASK,
    RQCM_SEL_DECAY
  } rqcm_sel_t;
endpackage

// ---- rtl/rqcm_time_counter.sv ----
// Purpose: congested time counter with prescaler
// Assumes: congested is a same-clock level
// Notes: saturates, clears on read, loadable for test
`timescale 1ns/100ps
`default_nettype none
`include "rqcm_consts.svh"
module rqcm_time_counter #(
  parameter int PRESCALE_W = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic congested,
  input wire logic [PRESCALE_W-1:0] prescale,
  input wire logic load,
  input wire logic [31:0] load_value,
  input wire logic read_clear,
  output logic [31:0] count
);
  // checked at elaboration: the prescale field must fit below the count
  if (PRESCALE_W < 1 || PRESCALE_W > 31) begin
    $error("rqcm_time_counter: bad PRESCALE_W");
  end
  logic [PRESCALE_W-1:0] tick; // congested cycles since the last step in this stretch
  logic [PRESCALE_W-1:0] next_tick;
  logic [31:0] next_count;
  logic step; // one prescaled period elapsed

  // prescaler and counter next values
  always_comb begin
    next_tick = tick;
    next_count = count;
    step = 1'b0;
    if (!congested || prescale == '0) begin
      next_tick = '0;
    end else if (tick + 1'b1 >= prescale) begin
      next_tick = '0;
      step = 1'b1;
    end else begin
      next_tick = tick + 1'b1;
    end
    if (load) begin
      next_count = load_value;
    end else if (read_clear) begin
      next_count = '0;
    end else if (step && prescale != '0 && count < `RQCM_TIME_MAX) begin
      next_count = count + 32'h00000001;
    end
  end

  // registers only
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tick <= '0;
      count <= '0;
    end else begin
      tick <= next_tick;
      count <= next_count;
    end
  end

  a_time_saturates: assert property (@(posedge clk) disable iff (rst)
    !load && count == `RQCM_TIME_MAX && !read_clear |=> count == `RQCM_TIME_MAX)
    else $error("time counter left its ceiling");
  a_time_read_clr: assert property (@(posedge clk) disable iff (rst)
    read_clear && !load |=> count == 32'h00000000)
    else $error("time counter not cleared by read");
  a_time_off: assert property (@(posedge clk) disable iff (rst)
    prescale == '0 && !load && !read_clear |=> count == $past(count))
    else $error("time counter ran with zero prescale");
endmodule
`default_nettype wire

// ---- rtl/rqcm_monitor.sv ----
// Purpose: receive input-queue congestion monitor, one port
// Assumes: fill level and packet strobe come from same-clock logic
// Notes: plain register port, read data one cycle after the strobe
//        packet steps beat decay, software writes beat both
//        threshold codes 8 and up are treated as monitoring off
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
`include "rqcm_consts.svh"
// Overview of operation
// - count packets received while fill exceeds threshold
// - event counter saturates at its maximum value
// - software may load both counters for test
// - writing one to status bit clears counter
// - zero event limit disables the event counter
// - decrement counter when decay interval passes unread
// - set interrupt status when count reaches limit
// - duration counter steps every N consecutive congested cycles
// - read returns duration value then clears it
// - zero prescale disables the duration counter
// - duration counter saturates at 0xffff
// - threshold n means fill n+1; zero disables
// - prescale one is every cycle, ffff 64k
module rqcm_monitor
  import rqcm_pkg::*;
#(
  parameter int FILL_W = 4,
  parameter logic [31:0] DECAY_DEFAULT = `RQCM_DECAY_DEFAULT
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [FILL_W-1:0] queue_fill,
  input wire logic packet_received,
  input wire logic [`RQCM_ADDR_W-1:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  output logic inbound_congestion_irq,
  output logic congested
);
  // checked at elaboration: narrower fill cannot hold code 7 plus one
  if (FILL_W < 4 || FILL_W > 16) begin
    $error("rqcm_monitor: FILL_W must be 4..16");
  end

  // register words, all 32 bits wide:
  //   count word: limit in the upper half, event count in the lower half
  //   time word: congested time, a read returns it and clears it
  //   control word: prescale in the lower half, fill threshold above it
  //   status word: bit 0 sticky, a read clears it, writing one clears the count
  //   mask word: bit 0; decay word: interval in cycles, zero stops decay

  // control state
  logic [15:0] congestion_event_count; // saturating event count
  logic [15:0] congestion_event_limit; // interrupt limit, zero disables
  logic [15:0] congested_time_prescale; // cycles per duration step
  logic [3:0] fill_threshold; // queue fill threshold code
  logic irq_status; // sticky congestion event
  logic irq_mask; // one lets the event reach the pin
  logic [31:0] error_decay_interval; // decay interval in cycles
  logic [31:0] decay_timer; // cycles since the last interval ended
  logic count_read; // a read seen in the current interval
  logic [31:0] congested_time_count; // from the duration counter
  // next values, one per register above
  logic [15:0] next_event_count;
  logic [15:0] next_limit;
  logic [15:0] next_prescale;
  logic [3:0] next_fill_threshold;
  logic next_irq_status;
  logic next_irq_mask;
  logic [31:0] next_decay_interval;
  logic [31:0] next_decay_timer;
  logic next_count_read;
  logic [31:0] next_rdata;
  logic next_irq;
  logic next_congested;
  rqcm_sel_t sel; // decoded register
  logic cong_now; // fill above threshold code (at least code plus one)
  logic decay_due; // interval ended with no read

  // address decode
  // full match only, so a stray address can never alias onto a counter
  always_comb begin
    unique case (addr)
      `RQCM_OFS_COUNT_LIMIT: sel = RQCM_SEL_COUNT;
      `RQCM_OFS_TIME: sel = RQCM_SEL_TIME;
      `RQCM_OFS_CTRL: sel = RQCM_SEL_CTRL;
      `RQCM_OFS_IRQ_STATUS: sel = RQCM_SEL_STAT;
      `RQCM_OFS_IRQ_MASK: sel = RQCM_SEL_MASK;
      `RQCM_OFS_DECAY: sel = RQCM_SEL_DECAY;
      default: sel = RQCM_SEL_NONE;
    endcase
  end

  // congestion detect; code 8 and up is reserved and treated as off
  // fill is compared against the code plus one, at full width to avoid wrap
  always_comb begin
    cong_now = 1'b0;
    if (fill_threshold != 4'h0 && fill_threshold < 4'h8) begin
      cong_now = {{(16-FILL_W){1'b0}}, queue_fill} >= {12'h000, fill_threshold} + 16'h0001;
    end
  end

  // event counter, limit, decay and interrupt next values
  always_comb begin
    next_event_count = congestion_event_count;
    next_limit = congestion_event_limit;
    next_prescale = congested_time_prescale;
    next_fill_threshold = fill_threshold;
    next_irq_mask = irq_mask;
    next_decay_interval = error_decay_interval;
    next_count_read = count_read || (rd && sel == RQCM_SEL_COUNT);
    next_decay_timer = decay_timer + 32'h00000001;
    decay_due = 1'b0;
    // decay timer runs free; an interval that ends unread drains one count
    if (error_decay_interval != 32'h00000000 && decay_timer + 32'h00000001 >= error_decay_interval) begin
      next_decay_timer = '0;
      next_count_read = 1'b0;
      decay_due = !count_read && !(rd && sel == RQCM_SEL_COUNT);
    end
    // count step; limit zero freezes it
    // a packet beats a decay in one cycle, so a busy port never loses a count
    if (congestion_event_limit != 16'h0000) begin
      if (packet_received && cong_now) begin
        if (congestion_event_count != `RQCM_EVT_MAX) begin
          next_event_count = congestion_event_count + 16'h0001;
        end else begin
          next_event_count = `RQCM_EVT_MAX;
        end
      end else if (decay_due && congestion_event_count != 16'h0000) begin
        next_event_count = congestion_event_count - 16'h0001;
      end
    end
    // software writes override hardware steps
    if (wr) begin
      unique case (sel)
        RQCM_SEL_COUNT: begin
          next_event_count = wdata[`RQCM_CNT_LSB +: 16];
          next_limit = wdata[`RQCM_LIMIT_LSB +: 16];
        end
        RQCM_SEL_CTRL: begin
          next_prescale = wdata[`RQCM_PRESCALE_LSB +: 16];
          next_fill_threshold = wdata[`RQCM_FILL_THR_LSB +: 4];
        end
        RQCM_SEL_STAT: begin
          if (wdata[0]) begin
            next_event_count = 16'h0000;
          end
        end
        RQCM_SEL_MASK: next_irq_mask = wdata[0];
        RQCM_SEL_DECAY: next_decay_interval = wdata;
        default: ;
      endcase
    end
    // sticky status: read clears, a new hit wins over the clear
    // status can only drop once the count has fallen below the limit or the limit is zero
    next_irq_status = irq_status;
    if (rd && sel == RQCM_SEL_STAT) begin
      next_irq_status = 1'b0;
    end
    if (congestion_event_limit != 16'h0000 && congestion_event_count >= congestion_event_limit) begin
      next_irq_status = 1'b1;
    end
    next_irq = next_irq_status && next_irq_mask;
    next_congested = cong_now;
  end

  // read data mux, valid only in the cycle after rd
  // unmapped reads return zero, so a stray probe looks like an idle port
  always_comb begin
    next_rdata = 32'h00000000;
    if (rd) begin
      unique case (sel)
        RQCM_SEL_COUNT: next_rdata = {congestion_event_limit, congestion_event_count};
        RQCM_SEL_TIME: next_rdata = congested_time_count;
        RQCM_SEL_CTRL: next_rdata = {12'h000, fill_threshold, congested_time_prescale};
        RQCM_SEL_STAT: next_rdata = {31'h00000000, irq_status};
        RQCM_SEL_MASK: next_rdata = {31'h00000000, irq_mask};
        RQCM_SEL_DECAY: next_rdata = error_decay_interval;
        default: next_rdata = 32'h00000000;
      endcase
    end
  end

  // registers only
  // every output leaves a flip-flop, so decode glitches never reach a pin
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      // decay starts armed so an unattended count still drains
      congestion_event_count <= 16'(`RQCM_RESET_WORD);
      congestion_event_limit <= 16'h0000;
      congested_time_prescale <= 16'h0000;
      fill_threshold <= 4'h0;
      irq_status <= 1'b0;
      irq_mask <= 1'b0;
      error_decay_interval <= DECAY_DEFAULT;
      decay_timer <= 32'h00000000;
      count_read <= 1'b0;
      rdata <= 32'h00000000;
      inbound_congestion_irq <= 1'b0;
      congested <= 1'b0;
    end else begin
      congestion_event_count <= next_event_count;
      congestion_event_limit <= next_limit;
      congested_time_prescale <= next_prescale;
      fill_threshold <= next_fill_threshold;
      irq_status <= next_irq_status;
      irq_mask <= next_irq_mask;
      error_decay_interval <= next_decay_interval;
      decay_timer <= next_decay_timer;
      count_read <= next_count_read;
      rdata <= next_rdata;
      inbound_congestion_irq <= next_irq;
      congested <= next_congested;
    end
  end

  // duration counter runs on the registered congestion level
  // that costs one cycle of lag but keeps the prescaler off the raw fill input
  rqcm_time_counter #(
    .PRESCALE_W(16)
  ) u_time (
    .clk(clk),
    .rst(rst),
    .congested(congested),
    .prescale(congested_time_prescale),
    .load(wr && sel == RQCM_SEL_TIME),
    .load_value(wdata),
    .read_clear(rd && sel == RQCM_SEL_TIME),
    .count(congested_time_count)
  );

  a_evt_increment: assert property (@(posedge clk) disable iff (rst)
    packet_received && cong_now && !wr && congestion_event_limit != 16'h0000
    && congestion_event_count != `RQCM_EVT_MAX
    |=> congestion_event_count == $past(congestion_event_count) + 16'h0001)
    else $error("event count did not step");
  a_evt_saturate: assert property (@(posedge clk) disable iff (rst)
    congestion_event_count == `RQCM_EVT_MAX && !wr && !decay_due
    |=> congestion_event_count == `RQCM_EVT_MAX)
    else $error("event count wrapped");
  a_evt_write: assert property (@(posedge clk) disable iff (rst)
    wr && sel == RQCM_SEL_COUNT |=> congestion_event_count == $past(wdata[15:0]))
    else $error("event count write lost");
  a_evt_clear: assert property (@(posedge clk) disable iff (rst)
    wr && sel == RQCM_SEL_STAT && wdata[0] |=> congestion_event_count == 16'h0000)
    else $error("status write did not clear count");
  a_evt_disabled: assert property (@(posedge clk) disable iff (rst)
    congestion_event_limit == 16'h0000 && !wr
    |=> congestion_event_count == $past(congestion_event_count))
    else $error("event count ran with zero limit");
  a_evt_decay: assert property (@(posedge clk) disable iff (rst)
    decay_due && !wr && !(packet_received && cong_now) && congestion_event_limit != 16'h0000
    && congestion_event_count != 16'h0000
    |=> congestion_event_count == $past(congestion_event_count) - 16'h0001)
    else $error("event count did not decay");
  a_irq_raise: assert property (@(posedge clk) disable iff (rst)
    congestion_event_limit != 16'h0000 && congestion_event_count >= congestion_event_limit
    |=> irq_status && (inbound_congestion_irq == irq_mask))
    else $error("limit reached without interrupt");
  a_read_time: assert property (@(posedge clk) disable iff (rst)
    rd && sel == RQCM_SEL_TIME |=> rdata == $past(congested_time_count))
    else $error("duration read returned wrong value");
  a_fill_thresh: assert property (@(posedge clk) disable iff (rst)
    fill_threshold == 4'h0 |-> !cong_now)
    else $error("congestion with monitoring off");
  c_irq_fires: cover property (@(posedge clk) disable iff (rst) inbound_congestion_irq);
  c_evt_saturated: cover property (@(posedge clk) disable iff (rst)
    congestion_event_count == `RQCM_EVT_MAX);
  c_decay_step: cover property (@(posedge clk) disable iff (rst) decay_due);
  c_time_read: cover property (@(posedge clk) disable iff (rst)
    rd && sel == RQCM_SEL_TIME && congested_time_count != 32'h00000000);
  // guards below exclude the software paths that legally override hardware,
  // so a firing means the hardware step itself went wrong
  a_status_sticky: assert property (@(posedge clk) disable iff (rst)
    irq_status && !(rd && sel == RQCM_SEL_STAT)
    |=> irq_status)
    else $error("status bit dropped without a read");
  a_status_read: assert property (@(posedge clk) disable iff (rst)
    rd && sel == RQCM_SEL_STAT
    && !(congestion_event_limit != 16'h0000 && congestion_event_count >= congestion_event_limit)
    |=> !irq_status)
    else $error("status read did not clear the bit");
  a_irq_masked: assert property (@(posedge clk) disable iff (rst)
    !irq_mask
    |-> !inbound_congestion_irq)
    else $error("masked event reached the pin");
  a_cong_on: assert property (@(posedge clk) disable iff (rst)
    fill_threshold != 4'h0 && fill_threshold < 4'h8 && queue_fill > fill_threshold
    |=> congested)
    else $error("fill above threshold not flagged");
  a_cong_off: assert property (@(posedge clk) disable iff (rst)
    queue_fill <= fill_threshold
    |=> !congested)
    else $error("fill below threshold flagged");
  a_decay_off: assert property (@(posedge clk) disable iff (rst)
    error_decay_interval == 32'h00000000
    |-> !decay_due)
    else $error("decay with interval zero");
  a_decay_floor: assert property (@(posedge clk) disable iff (rst)
    congestion_event_count == 16'h0000 && !wr && !(packet_received && cong_now)
    |=> congestion_event_count == 16'h0000)
    else $error("event count wrapped below zero");
  a_limit_write: assert property (@(posedge clk) disable iff (rst)
    wr && sel == RQCM_SEL_COUNT
    |=> congestion_event_limit == $past(wdata[31:16]))
    else $error("limit write lost");
  c_status_read: cover property (@(posedge clk) disable iff (rst)
    rd && sel == RQCM_SEL_STAT && irq_status);
endmodule
`default_nettype wire

// ---- testbench/rqcm_rx_queue_model.sv ----
// Purpose: receive queue stand-in driving fill level and packet strobes
// Assumes: shares the monitor clock
// Notes: slow mode leaves one idle cycle between packets
`timescale 1ns/100ps
`default_nettype none
module rqcm_rx_queue_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire logic [7:0] num_pkts,
  input wire logic slow,
  input wire logic [3:0] fill_level,
  output logic [3:0] queue_fill,
  output logic packet_received,
  output logic idle
);
  logic [7:0] left; // packets still to deliver
  logic gap; // idle slot in slow mode
  // fill follows the request one cycle later, packets drip out
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      queue_fill <= 4'h0;
      packet_received <= 1'b0;
      left <= 8'h00;
      gap <= 1'b0;
    end else begin
      queue_fill <= fill_level;
      gap <= slow & ~gap;
      packet_received <= (left != 8'h00) && !gap;
      // a new burst replaces whatever was left
      if (start) begin
        left <= num_pkts;
      end else if (left != 8'h00 && !gap) begin
        left <= left - 8'h01;
      end
    end
  end
  assign idle = (left == 8'h00) && !start;
endmodule
`default_nettype wire

// ---- testbench/rx_queue_congestion_monitor_tb.sv ----
// Purpose: self-checking bench for the congestion monitor
// Assumes: register port answers one cycle after the read strobe
// Notes: decay and duration checks allow a small phase slack
`timescale 1ns/100ps
`default_nettype none
`include "rqcm_consts.svh"
module rx_queue_congestion_monitor_tb;
  localparam logic [19:0] A_CNT = `RQCM_OFS_COUNT_LIMIT;
  localparam logic [19:0] A_TIME = `RQCM_OFS_TIME;
  localparam logic [19:0] A_CTRL = `RQCM_OFS_CTRL;
  localparam logic [19:0] A_STAT = `RQCM_OFS_IRQ_STATUS;
  localparam logic [19:0] A_MASK = `RQCM_OFS_IRQ_MASK;
  logic clk = 1'b0;
  logic rst, wr, rd, irq, congested, packet_received, start, slow, idle, rd_pend;
  logic [19:0] addr;
  logic [31:0] wdata, rdata;
  logic [3:0] queue_fill, fill_level;
  logic [7:0] num_pkts;
  logic [63:0] ent; // expected value and slack
  logic [63:0] q[$]; // notes of pending read results
  logic [15:0] rv; // random start count
  int num_errors, compares;
  rqcm_monitor #(.FILL_W(4)) DUT (.clk(clk), .rst(rst), .queue_fill(queue_fill),
    .packet_received(packet_received), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .inbound_congestion_irq(irq), .congested(congested));
  rqcm_rx_queue_model rxq (.clk(clk), .rst(rst), .start(start), .num_pkts(num_pkts),
    .slow(slow), .fill_level(fill_level), .queue_fill(queue_fill),
    .packet_received(packet_received), .idle(idle));
  // free-running 25 MHz clock
  always #20 clk = ~clk;
  // compare within slack below the expected value; unknowns never match
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] slack);
    bit ok;
    ok = (got === exp) || (slack != 0 && got <= exp && got >= exp - slack);
    compares++;
    if (!ok) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // read data stands only in the cycle after the strobe
  always @(posedge clk) rd_pend <= rd;
  always @(negedge clk) begin
    if (rd_pend) begin
      ent = q.pop_front();
      chk(rdata, ent[63:32], ent[31:0]);
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr_reg(input logic [19:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [19:0] a, input logic [31:0] e, input logic [31:0] s);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    q.push_back({e, s});
    @(posedge clk);
    rd <= 1'b0;
  endtask
  // burst of packets, bounded wait for the model to finish
  task automatic send(input logic [7:0] n, input logic s);
    int i;
    @(posedge clk);
    start <= 1'b1;
    num_pkts <= n;
    slow <= s;
    @(posedge clk);
    start <= 1'b0;
    for (i = 0; i < 600 && !idle; i++) @(posedge clk);
    tick(3);
  endtask
  task automatic fill(input logic [3:0] v);
    @(posedge clk);
    fill_level <= v;
    tick(3);
  endtask
  task automatic print_verdict();
    $display("compares=%0d num_errors=%0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // watchdog: the sequence needs well under 5000 cycles
  initial begin
    #800000;
    num_errors++;
    print_verdict();
  end
  initial begin
    rst = 1;
    {wr, rd, start, slow} = '0;
    addr = '0;
    wdata = '0;
    num_pkts = '0;
    fill_level = '0;
    num_errors = 0;
    compares = 0;
    void'($urandom(82719));
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    // reset values, then an unmapped place
    rd_reg(A_CNT, 32'h0, 0);
    rd_reg(A_TIME, 32'h0, 0);
    rd_reg(20'h13000, 32'h0, 0);
    wr_reg(`RQCM_OFS_DECAY, 32'h0);
    wr_reg(A_CTRL, 32'h0001_0000);
    fill(4'h2);
    chk({31'h0, congested}, 32'h1, 0);
    send(8'd4, 1'b0);
    rd_reg(A_CNT, 32'h0, 0);
    wr_reg(A_CNT, 32'h0003_0000);
    send(8'd2, 1'b1);
    rd_reg(A_CNT, 32'h0003_0002, 0);
    rd_reg(A_TIME, 32'h0, 0);
    fill(4'h1);
    chk({31'h0, congested}, 32'h0, 0);
    send(8'd3, 1'b0);
    rd_reg(A_CNT, 32'h0003_0002, 0);
    // limit hit while masked, then unmask, clear
    wr_reg(A_MASK, 32'h0);
    fill(4'h2);
    send(8'd1, 1'b0);
    tick(3);
    chk({31'h0, irq}, 32'h0, 0);
    wr_reg(A_MASK, 32'h1);
    tick(2);
    chk({31'h0, irq}, 32'h1, 0);
    wr_reg(A_STAT, 32'h1);
    rd_reg(A_CNT, 32'h0003_0000, 0);
    rd_reg(A_STAT, 32'h1, 0);
    rd_reg(A_STAT, 32'h0, 0);
    tick(3);
    chk({31'h0, irq}, 32'h0, 0);
    // loaded start value, then saturation
    rv = 16'($urandom_range(32'hff00, 32'h0));
    wr_reg(A_CNT, {16'hffff, rv});
    send(8'd2, 1'b1);
    rd_reg(A_CNT, {16'hffff, rv + 16'h2}, 0);
    wr_reg(A_CNT, 32'h0001_fffe);
    send(8'd3, 1'b0);
    rd_reg(A_CNT, 32'h0001_ffff, 0);
    // unread counter decays once per interval
    wr_reg(A_CNT, 32'h0010_000a);
    wr_reg(`RQCM_OFS_DECAY, 32'd20);
    tick(100);
    rd_reg(A_CNT, 32'h0010_0006, 2);
    wr_reg(`RQCM_OFS_DECAY, 32'h0);
    wr_reg(A_CNT, 32'h0);
    // duration counter, prescale four
    fill(4'h0);
    wr_reg(A_CTRL, 32'h0001_0004);
    fill(4'h2);
    tick(37);
    fill(4'h0);
    rd_reg(A_TIME, 32'd10, 1);
    rd_reg(A_TIME, 32'h0, 0);
    // prescale five: four-cycle stretches must never reach a step
    wr_reg(A_CTRL, 32'h0001_0005);
    repeat (5) begin
      fill(4'h2);
      fill(4'h0);
    end
    rd_reg(A_TIME, 32'h0, 0);
    wr_reg(A_TIME, 32'h0000_fffd);
    wr_reg(A_CTRL, 32'h0001_0001);
    fill(4'h2);
    tick(10);
    fill(4'h0);
    rd_reg(A_TIME, 32'h0000_ffff, 0);
    wr_reg(A_CTRL, 32'h0001_ffff);
    fill(4'h2);
    tick(200);
    fill(4'h0);
    rd_reg(A_TIME, 32'h0, 0);
    // threshold code zero switches monitoring off
    wr_reg(A_CTRL, 32'h0000_0001);
    fill(4'hf);
    chk({31'h0, congested}, 32'h0, 0);
    tick(5);
    print_verdict();
  end
endmodule
`default_nettype wire
